// ---- hdl/avg_pkg.sv ----
// Purpose: Constants, types and decode helpers for the current and power averager.
// Assumes: Samples arrive as one-cycle valid strobes from the converter sequencer.
// Notes: Averaging counts are powers of two, so the final division is a shift.
//
// How it works
// - A calculation starts only once both a shunt and a bus sample of the pair are held.
// - Power is the magnitude of the newest computed current times the bus sample of the same pair.
// - A calibration value of zero forces the power result to zero.
// - With an averaging count above one, results go to the accumulator, not the outputs.
// - Each computed current and power is added to the accumulator until the run is done.
// - When the run completes, the averaged current and power load the output registers.
// - Arithmetic runs in a fixed pipeline beside conversions and never holds off a sample.
// - The outputs need no framing from the host, so a chip select held low still works.
// - Averaging counts from 1 to 1024 apply the same to current and power.
// - Outputs hold until the next complete result, and reading them changes nothing.

package avg_pkg;

  localparam int SAMPLE_W = 16;
  localparam int CAL_W = 15;
  localparam int CUR_SHIFT = 11;
  localparam int POW_W = 32;
  localparam int AVG_SEL_W = 3;
  localparam int MAX_SHIFT = 10;
  localparam int SHIFT_W = 4;
  localparam int CNT_W = 11;
  localparam int CALC_LATENCY = 2;
  localparam int ACC_CUR_W = SAMPLE_W + MAX_SHIFT;
  localparam int ACC_POW_W = POW_W + MAX_SHIFT;
  localparam logic [SHIFT_W-1:0] SHIFT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;

  // ---------------------------------------------------------------
  // Run state, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FIRST = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  // ---------------------------------------------------------------
  // Averaging select to log2 of the count
  // ---------------------------------------------------------------
  function automatic logic [SHIFT_W-1:0] avg_shift_of(input logic [AVG_SEL_W-1:0] sel);
    case (sel)
      3'h0: avg_shift_of = 4'h0;
      3'h1: avg_shift_of = 4'h2;
      3'h2: avg_shift_of = 4'h4;
      3'h3: avg_shift_of = 4'h6;
      3'h4: avg_shift_of = 4'h7;
      3'h5: avg_shift_of = 4'h8;
      3'h6: avg_shift_of = 4'h9;
      default: avg_shift_of = 4'ha;
    endcase
  endfunction : avg_shift_of

endpackage : avg_pkg

// ---- hdl/calc_if.sv ----
// Purpose: Carries one calculation request and its result between engine and arithmetic.
// Assumes: One clock domain.
// Notes: The result follows the request by a fixed latency.
`timescale 1ns/10ps
`default_nettype none

interface calc_if;
  logic start;
  logic signed [avg_pkg::SAMPLE_W-1:0] shunt;
  logic [avg_pkg::SAMPLE_W-1:0] bus;
  logic [avg_pkg::CAL_W-1:0] cal;
  logic done;
  logic signed [avg_pkg::SAMPLE_W-1:0] current;
  logic [avg_pkg::POW_W-1:0] power;

  modport engine (output start, output shunt, output bus, output cal,
                  input done, input current, input power);
  modport calc (input start, input shunt, input bus, input cal,
                output done, output current, output power);
endinterface : calc_if

`default_nettype wire

// ---- hdl/power_calc.sv ----
// Purpose: Two-stage pipeline computing current, then power from that current.
// Assumes: Reset is already synchronised by the caller.
// Notes: Accepts a request every cycle, so it never stalls the sequencer.
`timescale 1ns/10ps
`default_nettype none

module power_calc (
  input wire logic clock,
  input wire logic rst_b,
  calc_if.calc ifc
);

  logic signed [avg_pkg::SAMPLE_W-1:0] cur1_ff, nxt_cur1;
  logic [avg_pkg::SAMPLE_W-1:0] bus1_ff, nxt_bus1;
  logic zero1_ff, nxt_zero1;
  logic v1_ff, nxt_v1;
  logic signed [avg_pkg::SAMPLE_W-1:0] current_ff, nxt_current;
  logic [avg_pkg::POW_W-1:0] power_ff, nxt_power;
  logic done_ff, nxt_done;
  logic signed [2*avg_pkg::SAMPLE_W-1:0] prod;
  logic [avg_pkg::SAMPLE_W-1:0] mag;

  // ---------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------
  always_comb begin
    prod = ifc.shunt * $signed({1'b0, ifc.cal});
    nxt_cur1 = prod[avg_pkg::CUR_SHIFT+avg_pkg::SAMPLE_W-1:avg_pkg::CUR_SHIFT];
    nxt_bus1 = ifc.bus;
    nxt_zero1 = (ifc.cal == '0);
    nxt_v1 = ifc.start;
    mag = cur1_ff[avg_pkg::SAMPLE_W-1] ? 16'(-cur1_ff) : 16'(cur1_ff);
    // Stage two multiplies the current just formed by the bus sample of the same pair
    nxt_power = zero1_ff ? '0 : 32'(mag) * 32'(bus1_ff);
    nxt_current = cur1_ff;
    nxt_done = v1_ff;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur1_ff <= '0;
      bus1_ff <= '0;
      zero1_ff <= 1'b0;
      v1_ff <= 1'b0;
      current_ff <= '0;
      power_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cur1_ff <= nxt_cur1;
      bus1_ff <= nxt_bus1;
      zero1_ff <= nxt_zero1;
      v1_ff <= nxt_v1;
      current_ff <= nxt_current;
      power_ff <= nxt_power;
      done_ff <= nxt_done;
    end
  end

  assign ifc.done = done_ff;
  assign ifc.current = current_ff;
  assign ifc.power = power_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_power_from_current: assert property (@(posedge clock) disable iff (!rst_b)
    v1_ff && !zero1_ff |=> power_ff == 32'($past(mag)) * 32'($past(bus1_ff)))
    else $error("power not current times bus");

  chk_zero_cal_power: assert property (@(posedge clock) disable iff (!rst_b)
    ifc.start && ifc.cal == '0 |-> ##2 (done_ff && power_ff == '0))
    else $error("power not zero with zero calibration");

endmodule : power_calc

`default_nettype wire

// ---- hdl/current_power_averager.sv ----
// Purpose: Pairs samples, runs the arithmetic and averages current and power.
// Assumes: shunt_cal and avg_sel are steady register values from the host side.
// Notes: avg_sel is taken at the first result of a run and held for that run.
`timescale 1ns/10ps
`default_nettype none

module current_power_averager (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic shunt_valid,
  input wire logic signed [avg_pkg::SAMPLE_W-1:0] shunt_data,
  input wire logic bus_valid,
  input wire logic [avg_pkg::SAMPLE_W-1:0] bus_data,
  input wire logic [avg_pkg::CAL_W-1:0] shunt_cal,
  input wire logic [avg_pkg::AVG_SEL_W-1:0] avg_sel,
  output logic signed [avg_pkg::SAMPLE_W-1:0] current_avg,
  output logic [avg_pkg::POW_W-1:0] power_avg,
  output logic result_valid
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_ff, rst_sync_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Sample pairing
  // ---------------------------------------------------------------
  calc_if ifc ();

  logic have_shunt_ff, nxt_have_shunt;
  logic have_bus_ff, nxt_have_bus;
  logic signed [avg_pkg::SAMPLE_W-1:0] shunt_ff, nxt_shunt;
  logic [avg_pkg::SAMPLE_W-1:0] bus_ff, nxt_bus;
  logic start;

  always_comb begin
    start = have_shunt_ff && have_bus_ff;
    nxt_have_shunt = have_shunt_ff && !start;
    nxt_have_bus = have_bus_ff && !start;
    nxt_shunt = shunt_ff;
    nxt_bus = bus_ff;
    // A sample landing on the start cycle is kept for the next pair
    if (shunt_valid) begin
      nxt_have_shunt = 1'b1;
      nxt_shunt = shunt_data;
    end
    if (bus_valid) begin
      nxt_have_bus = 1'b1;
      nxt_bus = bus_data;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      have_shunt_ff <= 1'b0;
      have_bus_ff <= 1'b0;
      shunt_ff <= '0;
      bus_ff <= '0;
    end else begin
      have_shunt_ff <= nxt_have_shunt;
      have_bus_ff <= nxt_have_bus;
      shunt_ff <= nxt_shunt;
      bus_ff <= nxt_bus;
    end
  end

  assign ifc.start = start;
  assign ifc.shunt = shunt_ff;
  assign ifc.bus = bus_ff;
  assign ifc.cal = shunt_cal;

  power_calc u_calc (
    .clock(clock),
    .rst_b(rst_sync_ff),
    .ifc(ifc.calc)
  );

  // ---------------------------------------------------------------
  // Averaging
  // ---------------------------------------------------------------
  avg_pkg::run_state_t state_ff, nxt_state;
  logic [avg_pkg::CNT_W-1:0] count_ff, nxt_count, cnt_now, run_len;
  logic [avg_pkg::SHIFT_W-1:0] shift_ff, nxt_shift, shift_now;
  logic signed [avg_pkg::ACC_CUR_W-1:0] acc_cur_ff, nxt_acc_cur, sum_cur, cur_ext, cur_div;
  logic [avg_pkg::ACC_POW_W-1:0] acc_pow_ff, nxt_acc_pow, sum_pow, pow_ext, pow_div;
  logic signed [avg_pkg::SAMPLE_W-1:0] current_avg_ff, nxt_current_avg;
  logic [avg_pkg::POW_W-1:0] power_avg_ff, nxt_power_avg;
  logic result_valid_ff, nxt_result_valid;
  logic first, last;

  always_comb begin
    first = (state_ff == avg_pkg::ST_FIRST);
    shift_now = first ? avg_pkg::avg_shift_of(avg_sel) : shift_ff;
    cnt_now = first ? avg_pkg::CNT_RESET : count_ff;
    run_len = avg_pkg::CNT_W'(1) << shift_now;
    last = (cnt_now == run_len - avg_pkg::CNT_W'(1));
    cur_ext = avg_pkg::ACC_CUR_W'(ifc.current);
    pow_ext = avg_pkg::ACC_POW_W'(ifc.power);
    // A new run starts from the fresh value, which clears the sums
    sum_cur = first ? cur_ext : acc_cur_ff + cur_ext;
    sum_pow = first ? pow_ext : acc_pow_ff + pow_ext;
    // Power-of-two counts let a shift stand in for a divider
    cur_div = sum_cur >>> shift_now;
    pow_div = sum_pow >> shift_now;
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_shift = shift_ff;
    nxt_acc_cur = acc_cur_ff;
    nxt_acc_pow = acc_pow_ff;
    nxt_current_avg = current_avg_ff;
    nxt_power_avg = power_avg_ff;
    nxt_result_valid = 1'b0;
    if (ifc.done) begin
      nxt_shift = shift_now;
      nxt_acc_cur = sum_cur;
      nxt_acc_pow = sum_pow;
      if (last) begin
        nxt_current_avg = cur_div[avg_pkg::SAMPLE_W-1:0];
        nxt_power_avg = pow_div[avg_pkg::POW_W-1:0];
        nxt_result_valid = 1'b1;
        nxt_state = avg_pkg::ST_FIRST;
        nxt_count = avg_pkg::CNT_RESET;
      end else begin
        nxt_state = avg_pkg::ST_RUN;
        nxt_count = cnt_now + avg_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= avg_pkg::ST_FIRST;
      count_ff <= avg_pkg::CNT_RESET;
      shift_ff <= avg_pkg::SHIFT_RESET;
      acc_cur_ff <= '0;
      acc_pow_ff <= '0;
      current_avg_ff <= '0;
      power_avg_ff <= '0;
      result_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      shift_ff <= nxt_shift;
      acc_cur_ff <= nxt_acc_cur;
      acc_pow_ff <= nxt_acc_pow;
      current_avg_ff <= nxt_current_avg;
      power_avg_ff <= nxt_power_avg;
      result_valid_ff <= nxt_result_valid;
    end
  end

  // Plain held registers: no read strobe or framing exists to disturb them
  assign current_avg = current_avg_ff;
  assign power_avg = power_avg_ff;
  assign result_valid = result_valid_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_ff);

  sequence pair_taken;
    start ##1 !have_shunt_ff || shunt_valid;
  endsequence

  sequence result_back;
    ##2 ifc.done;
  endsequence

  chk_start_needs_pair: assert property (
    ifc.done |-> $past(have_shunt_ff, 2) && $past(have_bus_ff, 2))
    else $error("calculation started without both samples");

  chk_calc_latency: assert property (
    pair_taken |-> ##1 ifc.done)
    else $error("result not back two cycles after start");

  chk_calc_no_stall: assert property (
    start |-> result_back)
    else $error("calculation stalled");

  chk_midrun_no_load: assert property (
    ifc.done && !last |=> !result_valid_ff && $stable(current_avg_ff) && $stable(power_avg_ff))
    else $error("outputs loaded before run end");

  chk_count_steps: assert property (
    ifc.done && !last |=> count_ff == $past(cnt_now) + 11'h001 && state_ff == avg_pkg::ST_RUN)
    else $error("sample count did not advance");

  chk_load_on_last: assert property (
    ifc.done && last |=> result_valid_ff && current_avg_ff == $past(cur_div[15:0]) &&
      power_avg_ff == $past(pow_div[31:0]))
    else $error("average not loaded at run end");

  chk_outputs_hold: assert property (
    !(ifc.done && last) |=> $stable(current_avg_ff) && $stable(power_avg_ff))
    else $error("outputs changed without a completed result");

  chk_run_clears: assert property (
    ifc.done && first |=> acc_cur_ff == $past(cur_ext) && acc_pow_ff == $past(pow_ext))
    else $error("accumulator not cleared at run start");

  chk_shift_range: assert property (
    ifc.done |-> shift_now <= 4'ha && (shift_now == shift_ff || first))
    else $error("averaging count changed inside a run");

endmodule : current_power_averager

`default_nettype wire

// ---- verification/sample_source.sv ----
// Purpose: Converter sequencer model feeding shunt and bus samples to the averager.
// Assumes: Strobes are one-cycle pulses launched at the falling clock edge.
// Notes: Each data line shows the inverse of its last value on a put where its own strobe is low.
`timescale 1ns/10ps
`default_nettype none

module sample_source (
  input wire logic clock,
  output logic shunt_valid,
  output logic signed [avg_pkg::SAMPLE_W-1:0] shunt_data,
  output logic bus_valid,
  output logic [avg_pkg::SAMPLE_W-1:0] bus_data
);
  initial begin
    shunt_valid = 1'b0;
    bus_valid = 1'b0;
    shunt_data = 16'h5a5a;
    bus_data = 16'ha5a5;
  end

  // One cycle of strobes; idle lines toggle so a strobe-less capture reads junk
  task automatic put(input logic ds, input logic [15:0] sh, input logic db,
                     input logic [15:0] bu);
    @(negedge clock);
    shunt_valid = ds;
    bus_valid = db;
    shunt_data = ds ? sh : ~shunt_data;
    bus_data = db ? bu : ~bus_data;
  endtask : put

  // --------------------------------------------------------------
  // Pair orders; modes 3 and 4 send a stale sample that must be replaced
  // --------------------------------------------------------------
  task automatic send_pair(input int mode, input logic [15:0] sh, input logic [15:0] bu,
                           input logic [15:0] junk);
    case (mode)
      0: put(1'b1, sh, 1'b1, bu);
      1: begin
        put(1'b1, sh, 1'b0, 16'h0000);
        put(1'b0, 16'h0000, 1'b1, bu);
      end
      2: begin
        put(1'b0, 16'h0000, 1'b1, bu);
        put(1'b1, sh, 1'b0, 16'h0000);
      end
      3: begin
        put(1'b1, junk, 1'b0, 16'h0000);
        put(1'b1, sh, 1'b0, 16'h0000);
        put(1'b0, 16'h0000, 1'b1, bu);
      end
      default: begin
        put(1'b0, 16'h0000, 1'b1, junk);
        put(1'b0, 16'h0000, 1'b1, bu);
        put(1'b1, sh, 1'b0, 16'h0000);
      end
    endcase
  endtask : send_pair
endmodule : sample_source

`default_nettype wire

// ---- verification/tb_current_power_averager.sv ----
// Purpose: Self-checking bench for the current and power averager.
// Assumes: shunt_cal and avg_sel change only between runs, with no result pending.
// Notes: Chip select framing lives outside this block, so nothing here exercises it.
`timescale 1ns/10ps
`default_nettype none

module tb_current_power_averager;
  logic clock = 1'b0;
  logic rst_b;
  logic [avg_pkg::CAL_W-1:0] shunt_cal;
  logic [avg_pkg::AVG_SEL_W-1:0] avg_sel;
  logic shunt_valid, bus_valid, result_valid;
  logic signed [avg_pkg::SAMPLE_W-1:0] shunt_data, current_avg, held_c;
  logic [avg_pkg::SAMPLE_W-1:0] bus_data;
  logic [avg_pkg::POW_W-1:0] power_avg, held_p;
  int mismatches = 0;
  int checks = 0;
  int seed;
  longint acc_c, acc_p;
  int cnt;
  logic signed [15:0] q_cur[$];
  logic [31:0] q_pow[$];

  always #20 clock = ~clock;

  current_power_averager current_power_averager_inst (.clock(clock), .rst_b(rst_b),
    .shunt_valid(shunt_valid), .shunt_data(shunt_data), .bus_valid(bus_valid),
    .bus_data(bus_data), .shunt_cal(shunt_cal), .avg_sel(avg_sel),
    .current_avg(current_avg), .power_avg(power_avg), .result_valid(result_valid));

  sample_source sample_source_inst (.clock(clock), .shunt_valid(shunt_valid),
    .shunt_data(shunt_data), .bus_valid(bus_valid), .bus_data(bus_data));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      mismatches++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : check

  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------
  // Reference model: integer arithmetic, one entry per finished run
  // --------------------------------------------------------------
  task automatic model_pair(input logic [15:0] sh, input logic [15:0] bu, input int n);
    longint prod;
    logic signed [15:0] cur;
    longint mag;
    prod = longint'($signed(sh)) * longint'(shunt_cal);
    cur = 16'(prod >>> 11);
    mag = (cur < 0) ? -longint'(cur) : longint'(cur);
    acc_c += cur;
    acc_p += mag * longint'(bu);
    cnt++;
    if (cnt == n) begin
      q_cur.push_back(16'(acc_c >>> $clog2(n)));
      q_pow.push_back(32'(acc_p >> $clog2(n)));
      acc_c = 0;
      acc_p = 0;
      cnt = 0;
    end
  endtask : model_pair

  task automatic pairs(input int sel, input logic [14:0] cal, input int num);
    int n;
    logic [15:0] sh, bu;
    n = 1 << ((sel == 0) ? 0 : (sel < 4 ? 2 * sel : sel + 3));
    @(negedge clock);
    avg_sel = 3'(sel);
    shunt_cal = cal;
    for (int i = 0; i < num; i++) begin
      sh = 16'($random(seed));
      bu = 16'($random(seed));
      model_pair(sh, bu, n);
      sample_source_inst.send_pair(($random(seed) & 32'h7fff) % 5, sh, bu,
                                   16'($random(seed)));
      if ($random(seed) & 1) sample_source_inst.put(1'b0, 16'h0000, 1'b0, 16'h0000);
    end
    sample_source_inst.put(1'b0, 16'h0000, 1'b0, 16'h0000);
    for (int w = 0; w < 20 && q_cur.size() != 0; w++) @(negedge clock);
    check("pending_results", 32'h0, 32'(q_cur.size()));
  endtask : pairs

  // Outputs are checked every cycle so a stray update between results is caught
  always @(negedge clock) begin
    if (rst_b === 1'b1) begin
      if (result_valid === 1'b1) begin
        if (q_cur.size() == 0) begin
          mismatches++;
          $display("BAD result_valid exp 0 got 1");
        end else begin
          held_c = q_cur.pop_front();
          held_p = q_pow.pop_front();
        end
      end
      check("current_avg", {16'h0000, held_c}, {16'h0000, current_avg});
      check("power_avg", held_p, power_avg);
    end
  end

  initial begin
    #(40 * 40000);
    mismatches++;
    stop_test();
  end

  initial begin
    seed = 32'hc6d9;
    rst_b = 1'b0;
    shunt_cal = 15'h0000;
    avg_sel = 3'h0;
    held_c = 16'h0000;
    held_p = 32'h00000000;
    acc_c = 0;
    acc_p = 0;
    cnt = 0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    for (int s = 0; s < 8; s++) begin
      pairs(s, 15'($random(seed)) | 15'h0001,
            1 << (s == 0 ? 2 : (s < 4 ? 2 * s : s + 3)));
    end
    pairs(1, 15'h0000, 8);
    pairs(2, 15'h7fff, 5);
    rst_b = 1'b0;
    #1;
    check("rst_current", 32'h0, {16'h0000, current_avg});
    check("rst_power", 32'h0, power_avg);
    check("rst_valid", 32'h0, {31'h0, result_valid});
    q_cur.delete();
    q_pow.delete();
    held_c = 16'h0000;
    held_p = 32'h00000000;
    acc_c = 0;
    acc_p = 0;
    cnt = 0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    pairs(1, 15'($random(seed)), 8);
    stop_test();
  end
endmodule : tb_current_power_averager

`default_nettype wire
